// ==== shared/stoc_consts.svh ====
// Timing counts, offsets, field positions and reset values of the stepper translator block
`ifndef STOC_CONSTS_SVH
`define STOC_CONSTS_SVH

`define STOC_CLK_MHZ        100
`define STOC_OFF_TIME_US    30
`define STOC_OFF_CYCLES     (`STOC_OFF_TIME_US * `STOC_CLK_MHZ)
`define STOC_TIMER_W        16
`define STOC_FAST_NUM       5
`define STOC_FAST_SHIFT     4
`define STOC_FAST_ROUND     8
`define STOC_HOME_INDEX     3'h1
`define STOC_LVL_ZERO       2'h0
`define STOC_LVL_DIAG       2'h1
`define STOC_LVL_FULL       2'h2
`define STOC_ADDR_W         8
`define STOC_ADDR_CONTROL   8'h00
`define STOC_ADDR_STATUS    8'h04
`define STOC_CTRL_SOFT_OFF  16
`define STOC_ST_POS_LSB     0
`define STOC_ST_MIXED_LSB   3
`define STOC_ST_SYNC_LSB    5
`define STOC_ST_ALLOW       7
`define STOC_ST_HOT         8
`define STOC_ST_PUMP        9
`define STOC_ST_LOCK        10

`endif

// ==== shared/stoc_pkg.sv ====
// Types shared by the stepper translator and output control files
package stoc_pkg;

  typedef struct packed {
    logic src_a;
    logic snk_a;
    logic src_b;
    logic snk_b;
  } stoc_gates_t;

  typedef struct packed {
    logic       neg;
    logic [1:0] level;
  } stoc_phase_t;

  typedef struct packed {
    logic step;
    logic dir;
    logic half;
  } stoc_cmd_t;

  typedef enum logic [1:0] {
    STOC_DRIVE,
    STOC_FAST,
    STOC_SLOW
  } stoc_chop_t;

endpackage

// ==== verilog/stoc_translator.sv ====
// Step translator: phase table index, home position and per-phase decay selection
`timescale 1ns/1ps
`default_nettype none
`include "stoc_consts.svh"

module stoc_translator
  import stoc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        home,
  input  wire stoc_cmd_t   cmd,
  // Translator state
  output logic [2:0]       index,
  output stoc_phase_t      phase1,
  output stoc_phase_t      phase2,
  output logic [1:0]       mixed
);

  // Phase 1 current for a table index; phase 2 lags it by two positions
  function automatic stoc_phase_t phase_of(input logic [2:0] i);
    phase_of.neg   = (i == 3'h3) || (i == 3'h4) || (i == 3'h5);
    phase_of.level = (i == 3'h0 || i == 3'h4) ? `STOC_LVL_FULL :
                     (i == 3'h2 || i == 3'h6) ? `STOC_LVL_ZERO : `STOC_LVL_DIAG;
  endfunction

  logic        step_d;
  logic [2:0]  delta;
  logic [2:0]  next_index;
  logic        rise;
  stoc_phase_t new1;
  stoc_phase_t new2;

  assign rise       = cmd.step & ~step_d;
  assign delta      = (cmd.half || !index[0]) ? 3'h1 : 3'h2;
  assign next_index = cmd.dir ? index + delta : index - delta;
  assign new1       = phase_of(next_index);
  assign new2       = phase_of(next_index - 3'h2);
  assign phase1     = phase_of(index);
  assign phase2     = phase_of(index - 3'h2);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_d <= 1'b0;
      index  <= `STOC_HOME_INDEX;
      mixed  <= 2'h3;
    end else begin
      step_d <= cmd.step;
      if (home) begin
        index <= `STOC_HOME_INDEX;
        mixed <= 2'h3;
      end else if (rise) begin
        index    <= next_index;
        mixed[0] <= new1.level < phase1.level;
        mixed[1] <= new2.level < phase2.level;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verilog/stoc_decay_timer.sv ====
// Fixed off-time timer for one bridge with fast then slow decay and rectifier control
`timescale 1ns/1ps
`default_nettype none
`include "stoc_consts.svh"

module stoc_decay_timer
  import stoc_pkg::*;
#(
  parameter int TW = `STOC_TIMER_W
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Control
  input  wire logic          clear,
  input  wire logic          trip,
  input  wire logic          zero,
  input  wire logic          mixed,
  input  wire logic [TW-1:0] off_len,
  // Decay state
  output stoc_chop_t         chop,
  output logic               sync_on
);

  logic [TW-1:0] cnt;
  logic [TW+2:0] scaled;
  logic [TW-1:0] fast_len;
  logic [TW-1:0] last;

  // Fast share is five sixteenths of the off-time, rounded
  assign scaled   = (TW+3)'({3'h0, off_len} * `STOC_FAST_NUM + `STOC_FAST_ROUND);
  assign fast_len = TW'(scaled >> `STOC_FAST_SHIFT);
  assign last     = (off_len == '0) ? '0 : off_len - 1'b1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chop    <= STOC_DRIVE;
      cnt     <= '0;
      sync_on <= 1'b1;
    end else if (clear) begin
      chop    <= STOC_DRIVE;
      cnt     <= '0;
      sync_on <= 1'b1;
    end else begin
      unique case (chop)
        STOC_DRIVE: begin
          cnt     <= '0;
          sync_on <= 1'b1;
          if (trip) begin
            chop <= (mixed && fast_len != '0) ? STOC_FAST : STOC_SLOW;
          end
        end
        STOC_FAST, STOC_SLOW: begin
          cnt <= cnt + 1'b1;
          if (zero) begin
            sync_on <= 1'b0;
          end
          if (cnt == last) begin
            chop <= STOC_DRIVE;
          end else if (chop == STOC_FAST && cnt == fast_len - 1'b1) begin
            chop <= STOC_SLOW;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== verilog/stoc_top.sv ====
// Stepper translator and bridge output control with a Wishbone register slave
//
// What this block does
// - Output-disable input high forces every bridge gate off; low lets control drive.
// - Step, direction, resolution inputs and translator keep working whatever the disable level.
// - Overtemperature or pump rail undervoltage holds all gates off until the fault clears.
// - Supply lockout holds all gates off and returns the translator to home.
// - Mixed decay runs fast decay for 31.25 percent of off-time, then slow.
// - During off-time the transistors matching the decay mode conduct, not body diodes.
// - Zero current seen during decay turns synchronous rectification off for that off-time.
// - Home is the 45 degree position, both phases at 70.71 percent, positive.
// - Eight half-step positions; full-step uses diagonals; direction high counts upward.
// - Each rising edge on the step input advances exactly one increment.
// - Resolution select low means full-step, high means half-step.
// - Direction low is clockwise, high counterclockwise, taken at the next step edge.
// - Per phase, lower new level selects mixed decay, higher or equal slow.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "stoc_consts.svh"

module stoc_top
  import stoc_pkg::*;
#(
  parameter int OFF_CYCLES = `STOC_OFF_CYCLES,
  parameter int TW         = `STOC_TIMER_W
)(
  // Clock and reset
  input  wire logic                    MCLK,
  input  wire logic                    RESET,
  // Wishbone slave
  input  wire logic                    WB_CYC_I,
  input  wire logic                    WB_STB_I,
  input  wire logic                    WB_WE_I,
  input  wire logic [`STOC_ADDR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]              WB_SEL_I,
  input  wire logic [31:0]             WB_DAT_I,
  output logic      [31:0]             WB_DAT_O,
  output logic                         WB_ACK_O,
  // Step interface
  input  wire logic                    STEP,
  input  wire logic                    DIR,
  input  wire logic                    RESOLUTION_SELECT,
  input  wire logic                    OUT_DISABLE,
  input  wire logic                    TRANSLATOR_RESET_N,
  // Protection
  input  wire logic                    OVER_TEMP,
  input  wire logic                    PUMP_RAIL_LOW,
  input  wire logic                    SUPPLY_LOCKOUT,
  // Current sense
  input  wire logic [1:0]              TRIP,
  input  wire logic [1:0]              ZERO_CURRENT,
  // Bridge drive
  output stoc_gates_t                  GATE_1,
  output stoc_gates_t                  GATE_2,
  output stoc_phase_t                  LEVEL_1,
  output stoc_phase_t                  LEVEL_2,
  output logic [1:0]                   DECAY_MIXED,
  output logic [2:0]                   POSITION
);

  // ****************************************************************
  // Register slave
  // ****************************************************************
  logic [31:0]   control;
  logic [31:0]   status;
  logic [31:0]   next_control;
  logic          ack;
  logic [31:0]   rdata;
  wire           wb_req     = WB_CYC_I & WB_STB_I & ~ack;
  wire           hit_ctrl   = WB_ADR_I == `STOC_ADDR_CONTROL;
  wire           hit_stat   = WB_ADR_I == `STOC_ADDR_STATUS;
  wire           wr_ctrl    = wb_req & WB_WE_I & hit_ctrl;
  wire [TW-1:0]  off_len    = control[TW-1:0];
  wire           soft_off   = control[`STOC_CTRL_SOFT_OFF];
  // Writable bits: the off-time field and the soft disable
  wire [31:0]    ctrl_mask  = (32'h00000001 << `STOC_CTRL_SOFT_OFF)
                              | ((32'h00000001 << TW) - 32'h00000001);

  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign next_control[gl*8 +: 8] = WB_SEL_I[gl] ? WB_DAT_I[gl*8 +: 8] : control[gl*8 +: 8];
    end
  endgenerate

  assign rdata = hit_ctrl ? control : hit_stat ? status : 32'h00000000;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      control  <= 32'(OFF_CYCLES);
      ack      <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      ack <= wb_req;
      if (wr_ctrl) begin
        control <= next_control & ctrl_mask;
      end
      if (wb_req && !WB_WE_I) begin
        WB_DAT_O <= rdata;
      end
    end
  end

  assign WB_ACK_O = ack;

  // ****************************************************************
  // Translator
  // ****************************************************************
  stoc_cmd_t   cmd;
  stoc_phase_t phase [2];
  logic [2:0]  index;
  logic [1:0]  mixed;
  wire         home = SUPPLY_LOCKOUT | ~TRANSLATOR_RESET_N;

  assign cmd.step = STEP;
  assign cmd.dir  = DIR;
  assign cmd.half = RESOLUTION_SELECT;

  stoc_translator u_translator (
    .clk    (MCLK),
    .rst    (RESET),
    .home   (home),
    .cmd    (cmd),
    .index  (index),
    .phase1 (phase[0]),
    .phase2 (phase[1]),
    .mixed  (mixed)
  );

  // ****************************************************************
  // Output permission
  // ****************************************************************
  // Faults gate the bridge live, so outputs return on the first clock edge after the fault clears
  wire allow = ~(OUT_DISABLE | soft_off | home
                 | OVER_TEMP | PUMP_RAIL_LOW);

  // ****************************************************************
  // Per-bridge chopping and gate mapping
  // ****************************************************************
  stoc_chop_t  chop [2];
  logic [1:0]  sync_on;
  stoc_gates_t raw [2];
  stoc_gates_t gate_q [2];

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_bridge
      wire pos  = ~phase[gp].neg;
      wire live = phase[gp].level != `STOC_LVL_ZERO;

      stoc_decay_timer #(
        .TW (TW)
      ) u_timer (
        .clk     (MCLK),
        .rst     (RESET),
        .clear   (home),
        .trip    (TRIP[gp]),
        .zero    (ZERO_CURRENT[gp]),
        .mixed   (mixed[gp]),
        .off_len (off_len),
        .chop    (chop[gp]),
        .sync_on (sync_on[gp])
      );

      // Drive: diagonal pair; fast: reverse diagonal; slow: both sinks
      wire drv  = live && chop[gp] == STOC_DRIVE;
      wire fast = live && chop[gp] == STOC_FAST && sync_on[gp];
      wire slow = live && chop[gp] == STOC_SLOW;
      assign raw[gp].src_a = (drv & pos) | (fast & ~pos);
      assign raw[gp].snk_b = (drv & pos) | (fast & ~pos)
                             | (slow & (pos | sync_on[gp]));
      assign raw[gp].src_b = (drv & ~pos) | (fast & pos);
      assign raw[gp].snk_a = (drv & ~pos) | (fast & pos)
                             | (slow & (~pos | sync_on[gp]));

      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          gate_q[gp] <= 4'h0;
        end else begin
          gate_q[gp] <= allow ? raw[gp] : 4'h0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Status and outputs
  // ****************************************************************
  always_comb begin
    status                                   = 32'h00000000;
    status[`STOC_ST_POS_LSB +: 3]            = index;
    status[`STOC_ST_MIXED_LSB +: 2]          = mixed;
    status[`STOC_ST_SYNC_LSB +: 2]           = sync_on;
    status[`STOC_ST_ALLOW]                   = allow;
    status[`STOC_ST_HOT]                     = OVER_TEMP;
    status[`STOC_ST_PUMP]                    = PUMP_RAIL_LOW;
    status[`STOC_ST_LOCK]                    = SUPPLY_LOCKOUT;
  end

  assign GATE_1      = gate_q[0];
  assign GATE_2      = gate_q[1];
  assign LEVEL_1     = phase[0];
  assign LEVEL_2     = phase[1];
  assign DECAY_MIXED = mixed;
  assign POSITION    = index;

endmodule
`default_nettype wire

// ==== dv/stoc_step_gen.sv ====
// Step pulse source playing the controller side of the step link
`timescale 1ns/1ps
`default_nettype none
module stoc_step_gen (
  // Clock
  input  wire logic clk,
  // Step link
  output logic      step,
  output logic      dir,
  output logic      half
);
  initial begin
    step = 1'b0;
    dir  = 1'b0;
    half = 1'b0;
  end
  // Caller enters just after a rising edge; direction and size are set ahead and held past the edge
  task automatic pulse(input logic d, input logic h);
    dir <= d;
    half <= h;
    @(posedge clk);
    step <= 1'b1;
    repeat (2) @(posedge clk);
    step <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/stoc_props.sv ====
// Port-level assertions for the stepper translator top
`timescale 1ns/1ps
`default_nettype none
module stoc_props
  import stoc_pkg::*;
(
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RESET,
  // Bus handshake
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  // Step link and protection
  input wire logic        STEP,
  input wire logic        DIR,
  input wire logic        RESOLUTION_SELECT,
  input wire logic        OUT_DISABLE,
  input wire logic        TRANSLATOR_RESET_N,
  input wire logic        OVER_TEMP,
  input wire logic        PUMP_RAIL_LOW,
  input wire logic        SUPPLY_LOCKOUT,
  // Bridge drive
  input wire stoc_gates_t GATE_1,
  input wire stoc_gates_t GATE_2,
  input wire stoc_phase_t LEVEL_1,
  input wire stoc_phase_t LEVEL_2,
  input wire logic [1:0]  DECAY_MIXED,
  input wire logic [2:0]  POSITION
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // Phase table row of one index
  function automatic stoc_phase_t lv(input logic [2:0] i);
    lv.neg   = i inside {3'h3, 3'h4, 3'h5};
    lv.level = i[0] ? 2'h1 : (i[1] ? 2'h0 : 2'h2);
  endfunction
  wire logic run  = TRANSLATOR_RESET_N && !SUPPLY_LOCKOUT;
  wire logic dark = (GATE_1 == 4'h0) && (GATE_2 == 4'h0);
  wire logic flt  = OVER_TEMP || PUMP_RAIL_LOW;
  chk_disable_dark: assert property (OUT_DISABLE && $past(OUT_DISABLE) |-> dark)
    else $error("gates on while disabled");
  chk_fault_dark: assert property (flt && $past(flt) |-> dark)
    else $error("gates on during fault");
  chk_lockout_home: assert property (SUPPLY_LOCKOUT && $past(SUPPLY_LOCKOUT) |-> dark && POSITION == 3'h1)
    else $error("lockout not holding home");
  chk_half_step: assert property (STEP && !$past(STEP) && run && RESOLUTION_SELECT
    |=> POSITION == $past(POSITION) + ($past(DIR) ? 3'h1 : 3'h7))
    else $error("half step wrong");
  chk_full_step: assert property (STEP && !$past(STEP) && run && !RESOLUTION_SELECT && POSITION[0]
    |=> POSITION == $past(POSITION) + ($past(DIR) ? 3'h2 : 3'h6))
    else $error("full step wrong");
  chk_hold_still: assert property (!(STEP && !$past(STEP)) && run |=> $stable(POSITION) || !run)
    else $error("position moved without step");
  chk_level_table: assert property (LEVEL_1 == lv(POSITION) && LEVEL_2 == lv(POSITION - 3'h2))
    else $error("phase levels wrong");
  chk_mixed_drop: assert property (STEP && !$past(STEP) && run |=> DECAY_MIXED ==
    {LEVEL_2.level < $past(LEVEL_2.level), LEVEL_1.level < $past(LEVEL_1.level)})
    else $error("decay choice wrong");
  chk_ack_once: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a single pulse");
endmodule
bind stoc_top stoc_props u_props (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench of the stepper translator top against a step model
`timescale 1ns/1ps
`default_nettype none
module tb
  import stoc_pkg::*;
;
  // ****
  // Signals
  // ****
  logic        mclk  = 1'b0;
  logic        reset = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [3:0]  flt   = 4'h0;
  logic        rn    = 1'b1;
  logic [1:0]  trip  = 2'h0;
  logic [1:0]  zc    = 2'h0;
  wire  logic  step, dir, half;
  logic [31:0] rdat, dat_o;
  logic        ack;
  stoc_gates_t g1, g2;
  stoc_phase_t l1, l2;
  logic [1:0]  dm;
  logic [2:0]  pos;
  int          err_total = 0;
  int          tests_run = 0;
  int          mp = 1;
  logic [1:0]  mm = 2'h3;
  int          lt [8] = '{2, 1, 0, 1, 2, 1, 0, 1};
  logic [15:0] r = 16'hF408;
  initial begin
    forever #5 mclk = ~mclk;
  end
  stoc_top #(.OFF_CYCLES(32)) dut (.MCLK(mclk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .STEP(step), .DIR(dir), .RESOLUTION_SELECT(half), .OUT_DISABLE(flt[3]),
    .TRANSLATOR_RESET_N(rn), .OVER_TEMP(flt[2]), .PUMP_RAIL_LOW(flt[1]),
    .SUPPLY_LOCKOUT(flt[0]), .TRIP(trip), .ZERO_CURRENT(zc), .GATE_1(g1), .GATE_2(g2),
    .LEVEL_1(l1), .LEVEL_2(l2), .DECAY_MIXED(dm), .POSITION(pos));
  stoc_step_gen gen (.clk(mclk), .step(step), .dir(dir), .half(half));
  // ****
  // Tasks
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_state();
    int j = (mp + 6) % 8;
    cmp(pos, mp);
    cmp(l1, (mp > 2 && mp < 6) * 4 + lt[mp]);
    cmp(l2, (j > 2 && j < 6) * 4 + lt[j]);
    cmp(dm, mm);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge mclk);
    while (ack !== 1'b1) begin
      n++;
      @(posedge mclk);
    end
    rdat = dat_o;
    cmp(n, 1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end
    else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    int o1, o2, f, s, z;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    cmp_state();
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    cmp(rdat, 32);
    wb(1'b1, 8'h00, 32'hFFFF0014, 4'h3);
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    cmp(rdat, 32'h14);
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    cmp(rdat, 0);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    cmp(rdat, 32'hF9);
    for (int k = 0; k < 48; k++) begin
      r = lfsr(r);
      flt <= {r[3], 3'h0};
      gen.pulse(r[0], r[1]);
      o1 = lt[mp];
      o2 = lt[(mp + 6) % 8];
      mp = (mp + (r[0] ? 1 : 7) * (r[1] ? 1 : mp % 2 + 1)) % 8;
      mm = {lt[(mp + 6) % 8] < o2, lt[mp] < o1};
      cmp_state();
    end
    for (int k = 0; k < 4; k++) begin
      flt <= 4'h1 << k;
      repeat (3) @(posedge mclk);
      cmp({g1, g2}, 0);
    end
    flt <= 4'h0;
    rn <= 1'b0;
    mp = 1;
    mm = 2'h3;
    gen.pulse(1'b1, 1'b1);
    cmp_state();
    rn <= 1'b1;
    repeat (3) @(posedge mclk);
    cmp({g1, g2}, 8'h99);
    wb(1'b1, 8'h00, 32'h00010014, 4'h7);
    repeat (2) @(posedge mclk);
    cmp({g1, g2}, 0);
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    cmp(rdat, 32'h00010014);
    wb(1'b1, 8'h00, 32'h0, 4'h4);
    repeat (2) @(posedge mclk);
    cmp({g1, g2}, 8'h99);
    for (int k = 0; k < 2; k++) begin
      zc <= k ? 2'h3 : 2'h0;
      trip <= 2'h3;
      @(posedge mclk);
      trip <= 2'h0;
      f = 0;
      s = 0;
      z = 0;
      repeat (30) begin
        @(posedge mclk);
        f += (g1 === 4'h6) + (g2 === 4'h6);
        s += (g1 === 4'h5) + (g2 === 4'h5);
        z += (g1 === 4'h1) + (g2 === 4'h1);
      end
      cmp(s, k ? 0 : 28);
      cmp(z, k ? 28 : 0);
      if (k == 0) cmp(f, 12);
    end
    print_verdict();
  end
  initial begin
    #50000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
